//--- rtl/bbps_pkg.sv
package bbps_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] OFS_SWITCHING_CONFIG    = 8'h01;
	localparam logic [7:0] OFS_PEAK_CURRENT_LIMITS = 8'h03;
	localparam logic [7:0] OFS_CONTROL_LOOP_CONFIG = 8'h04;

	localparam int BIT_MODE_BUCK_ONLY         = 2;
	localparam int BIT_ZERO_CROSS_CMP_DISABLE = 4;
	localparam int BIT_ADAPTIVE_LIMIT_DISABLE = 1;
	localparam int BIT_INTEGRATOR_ENABLE      = 2;
	localparam int BIT_SUPPLY_SWO_FORCE_INPUT = 0;
	localparam int LSB_PRIMARY_PEAK_LIMIT     = 0;
	localparam int LSB_SECONDARY_PEAK_LIMIT   = 4;

	localparam logic [7:0] RST_SWITCHING_CONFIG    = 8'h00;
	localparam logic [7:0] RST_PEAK_CURRENT_LIMITS = 8'h00;
	localparam logic [7:0] RST_CONTROL_LOOP_CONFIG = 8'h04;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS        = 50000;
	localparam int CHARGE_TIMEOUT_NS    = 500;
	localparam int FREEWHEEL_NS         = 30;
	localparam int CHARGE_TIMEOUT_CYC   = (CHARGE_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
	localparam int FREEWHEEL_CYC_RAW    = (FREEWHEEL_NS * 1000 + CLK_PERIOD_PS - 1)
	                                      / CLK_PERIOD_PS;
	localparam int FREEWHEEL_CYC        = (FREEWHEEL_CYC_RAW < 1) ? 1 : FREEWHEEL_CYC_RAW;
	localparam int TMR_W                = 4;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [4:0] {
		BBPS_IDLE   = 5'b00001,
		BBPS_PH1    = 5'b00010,
		BBPS_PH2    = 5'b00100,
		BBPS_PH3    = 5'b01000,
		BBPS_PH4    = 5'b10000
	} bbps_phase_e;

	typedef struct packed {
		logic input_high_switch;
		logic output_high_switch;
		logic input_low_switch;
		logic output_low_switch;
	} bbps_switch_s;

	typedef struct packed {
		logic peak_primary;
		logic peak_total;
		logic valley;
		logic zero_cross;
		logic vin_above_vout;
		logic vin_below_uvlo;
		logic vout_at_target;
		logic vout_above_min;
	} bbps_cmp_s;

	typedef struct packed {
		logic [3:0] primary_peak_limit;
		logic [3:0] secondary_peak_limit;
		logic       adaptive_on;
		logic       valley_zero;
	} bbps_limits_s;

endpackage

//--- rtl/bbps_cmp_sync.sv
`timescale 1ns/10ps
module bbps_cmp_sync
	import bbps_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	// ----------------------------------------
	// Two-stage synchroniser per bit
	// ----------------------------------------
	logic [WIDTH-1:0] meta;

	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta[i]     <= 1'b0;
					sync_out[i] <= 1'b0;
				end else if (ce) begin
					meta[i]     <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

//--- rtl/bbps_phase_timer.sv
`timescale 1ns/10ps
module bbps_phase_timer
	import bbps_pkg::*;
#(
	parameter int W = TMR_W
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              expired
);
	// ----------------------------------------
	// Down counter, reload wins over count
	// ----------------------------------------
	logic [W-1:0] count;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (ce) begin
			if (load)
				count <= load_val;
			else if (count != '0)
				count <= count - 1'b1;
		end
	end

	assign expired = (count == '0) && !load;
endmodule

//--- rtl/bbps_sequencer.sv
`timescale 1ns/10ps
// How it works
// - Two switches on per phase, fixed pairs
// - Mode bit clear selects buck-boost sequencing
// - Charge in phase 2 to primary peak
// - Vin above Vout: phase 1 to total/timeout
// - Vin not above: phase 1 to valley/timeout
// - Phase 3 discharges, then freewheel phase 4
// - CCM phase 4 ~30ns only if comparator off
// - Buck-only: phase 1 to peak, then 3
// - Adaptive off: fixed peaks, zero valley
// - Primary peak crossing starts phase 1 timeout
// - Start-up forces DCM and soft-start peaks
// - Comparator off: valley acts as zero point
// - Comparator on: CCM skips phase 4
// - Adaptive with comparator: zero crossing freewheels
// - Integrator bit selects integrating control
// - Input helper on only below lockout
// - Switchover clear, started and Vout ok: keep running
// - Forced switchover shuts down; else flag
module bbps_sequencer
	import bbps_pkg::*;
#(
	parameter int TIMEOUT_CYC  = CHARGE_TIMEOUT_CYC,
	parameter int FWHEEL_CYC   = FREEWHEEL_CYC,
	parameter int SS_PEAK_A    = 4,
	parameter int SS_PEAK_B    = 2
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         enable,
	input  wire logic         reg_wr,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	output logic      [7:0]   reg_rdata,
	input  wire bbps_cmp_s    cmp_in,
	output bbps_switch_s      switches,
	output logic              input_helper_on,
	output logic              integrator_on,
	output bbps_limits_s      limits,
	output logic              ccm_allowed,
	output logic              input_uvlo_flag,
	output logic              irq,
	output logic              running
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 15 || FWHEEL_CYC < 1 || FWHEEL_CYC > 15) begin : g_tmr
		$error("bbps_sequencer: timer counts must be 1..15");
	end
	if (SS_PEAK_A < 0 || SS_PEAK_A > 15 || SS_PEAK_B < 0 || SS_PEAK_B > 15) begin : g_ss
		$error("bbps_sequencer: soft-start limits must be 0..15");
	end

	localparam logic [TMR_W-1:0] TO_LOAD = TMR_W'(TIMEOUT_CYC - 1);
	localparam logic [TMR_W-1:0] FW_LOAD = TMR_W'(FWHEEL_CYC - 1);
	localparam logic [3:0]       SS_A    = 4'(SS_PEAK_A);
	localparam logic [3:0]       SS_B    = 4'(SS_PEAK_B);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] switching_config;
	logic [7:0] peak_current_limits;
	logic [7:0] control_loop_config;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			switching_config    <= RST_SWITCHING_CONFIG;
			peak_current_limits <= RST_PEAK_CURRENT_LIMITS;
			control_loop_config <= RST_CONTROL_LOOP_CONFIG;
		end else if (ce && reg_wr) begin
			unique case (reg_addr)
				OFS_SWITCHING_CONFIG:    switching_config    <= reg_wdata;
				OFS_PEAK_CURRENT_LIMITS: peak_current_limits <= reg_wdata;
				OFS_CONTROL_LOOP_CONFIG: control_loop_config <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Unmapped addresses read as zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			unique case (reg_addr)
				OFS_SWITCHING_CONFIG:    reg_rdata <= switching_config;
				OFS_PEAK_CURRENT_LIMITS: reg_rdata <= peak_current_limits;
				OFS_CONTROL_LOOP_CONFIG: reg_rdata <= control_loop_config;
				default:                 reg_rdata <= 8'h00;
			endcase
		end
	end

	logic buck_only;
	logic zero_cross_cmp_disable;
	logic adaptive_limit_disable;
	logic supply_switchover_force_input;
	logic [3:0] primary_peak_limit;
	logic [3:0] secondary_peak_limit;

	assign buck_only                     = switching_config[BIT_MODE_BUCK_ONLY];
	assign zero_cross_cmp_disable        = switching_config[BIT_ZERO_CROSS_CMP_DISABLE];
	assign adaptive_limit_disable        = control_loop_config[BIT_ADAPTIVE_LIMIT_DISABLE];
	assign supply_switchover_force_input = switching_config[BIT_SUPPLY_SWO_FORCE_INPUT];
	assign primary_peak_limit   = peak_current_limits[LSB_PRIMARY_PEAK_LIMIT +: 4];
	assign secondary_peak_limit = peak_current_limits[LSB_SECONDARY_PEAK_LIMIT +: 4];

	// ----------------------------------------
	// Comparator synchronisation
	// ----------------------------------------
	bbps_cmp_s cmp;

	bbps_cmp_sync #(
		.WIDTH ($bits(bbps_cmp_s))
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.async_in (cmp_in),
		.sync_out (cmp)
	);

	// ----------------------------------------
	// Start-up and supply supervision
	// ----------------------------------------
	logic started;

	// Start-up holds until the output first reaches target
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			started <= 1'b0;
		end else if (ce) begin
			if (!running)
				started <= 1'b0;
			else if (cmp.vout_at_target)
				started <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			running <= 1'b0;
		end else if (ce) begin
			if (!enable)
				running <= 1'b0;
			else if (!running)
				running <= !cmp.vin_below_uvlo;
			else if (cmp.vin_below_uvlo && supply_switchover_force_input)
				running <= 1'b0;
			else if (cmp.vin_below_uvlo && started && !cmp.vout_above_min)
				running <= 1'b0;
			else if (cmp.vin_below_uvlo && !started)
				running <= 1'b0;
		end
	end

	// Flag is sticky; set wins over the register write that clears it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			input_uvlo_flag <= 1'b0;
		end else if (ce) begin
			if (running && cmp.vin_below_uvlo && !supply_switchover_force_input)
				input_uvlo_flag <= 1'b1;
			else if (reg_wr && reg_addr == OFS_SWITCHING_CONFIG)
				input_uvlo_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq             <= 1'b0;
			input_helper_on <= 1'b0;
			integrator_on   <= 1'b0;
		end else if (ce) begin
			irq             <= input_uvlo_flag;
			input_helper_on <= running && cmp.vin_below_uvlo;
			integrator_on   <= control_loop_config[BIT_INTEGRATOR_ENABLE];
		end
	end

	// ----------------------------------------
	// Limit selection
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			limits      <= '0;
			ccm_allowed <= 1'b0;
		end else if (ce) begin
			ccm_allowed <= started;
			limits.adaptive_on <= started && !adaptive_limit_disable;
			limits.valley_zero <= !started || adaptive_limit_disable;
			if (started) begin
				limits.primary_peak_limit   <= primary_peak_limit;
				limits.secondary_peak_limit <= secondary_peak_limit;
			end else begin
				limits.primary_peak_limit   <= SS_A;
				limits.secondary_peak_limit <= SS_B;
			end
		end
	end

	// ----------------------------------------
	// Phase sequencer
	// ----------------------------------------
	bbps_phase_e phase;
	bbps_phase_e next_phase;
	logic        to_load;
	logic        fw_load;
	logic        to_expired;
	logic        fw_expired;
	logic        ccm;
	logic        valley_hit;

	// Discontinuous whenever CCM is barred or the valley is pinned at zero
	assign ccm        = ccm_allowed && !limits.valley_zero;
	assign valley_hit = zero_cross_cmp_disable ? cmp.valley
	                  : (cmp.valley || cmp.zero_cross);

	bbps_phase_timer u_timeout (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.load     (to_load),
		.load_val (TO_LOAD),
		.expired  (to_expired)
	);

	bbps_phase_timer u_freewheel (
		.clk      (clk),
		.rst      (rst),
		.ce       (ce),
		.load     (fw_load),
		.load_val (FW_LOAD),
		.expired  (fw_expired)
	);

	// Charge entry from a non-charge phase
	function automatic bbps_phase_e charge_entry(input logic bo);
		charge_entry = bo ? BBPS_PH1 : BBPS_PH2;
	endfunction

	always_comb begin
		next_phase = phase;
		unique case (phase)
			BBPS_IDLE: begin
				if (running)
					next_phase = charge_entry(buck_only);
			end
			BBPS_PH2: begin
				if (buck_only)
					next_phase = BBPS_PH1;
				else if (cmp.peak_primary)
					next_phase = BBPS_PH1;
			end
			BBPS_PH1: begin
				if (buck_only) begin
					if (cmp.peak_primary || to_expired)
						next_phase = BBPS_PH3;
				end else if (cmp.vin_above_vout) begin
					if (cmp.peak_total || to_expired)
						next_phase = BBPS_PH3;
				end else if (to_expired || cmp.valley) begin
					next_phase = BBPS_PH3;
				end
			end
			BBPS_PH3: begin
				if (!limits.adaptive_on || !zero_cross_cmp_disable) begin
					if (cmp.zero_cross)
						next_phase = BBPS_PH4;
					else if (valley_hit)
						next_phase = (ccm && !zero_cross_cmp_disable)
						           ? charge_entry(buck_only)
						           : BBPS_PH4;
				end else if (valley_hit) begin
					next_phase = BBPS_PH4;
				end
			end
			BBPS_PH4: begin
				// CCM freewheel is a fixed short slot; DCM waits for demand
				if (ccm ? fw_expired : !cmp.peak_primary)
					next_phase = charge_entry(buck_only);
			end
		endcase
		if (!running)
			next_phase = BBPS_IDLE;
	end

	assign to_load = (next_phase == BBPS_PH1) && (phase != BBPS_PH1);
	assign fw_load = (next_phase == BBPS_PH4) && (phase != BBPS_PH4);

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			phase <= BBPS_IDLE;
		else if (ce)
			phase <= next_phase;
	end

	// Switch pairs registered from the next phase so outputs track the state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			switches <= '0;
		end else if (ce) begin
			unique case (next_phase)
				BBPS_PH1: switches <= '{1'b1, 1'b1, 1'b0, 1'b0};
				BBPS_PH2: switches <= '{1'b1, 1'b0, 1'b0, 1'b1};
				BBPS_PH3: switches <= '{1'b0, 1'b1, 1'b1, 1'b0};
				BBPS_PH4: switches <= '{1'b0, 1'b0, 1'b1, 1'b1};
				default:  switches <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_ph2_peak;
		ce && phase == BBPS_PH2 && cmp.peak_primary && running && !buck_only;
	endsequence

	AST_TWO_SWITCHES: assert property (@(posedge clk) disable iff (rst)
		switches != '0 |-> $countones(switches) == 2)
		else $error("switch count not two");
	AST_BUCK_NO_PH2: assert property (@(posedge clk) disable iff (rst)
		ce && buck_only && phase != BBPS_PH2 |=> phase != BBPS_PH2)
		else $error("phase 2 used in buck-only");
	AST_PH2_TO_PH1: assert property (@(posedge clk) disable iff (rst)
		s_ph2_peak |=> phase == BBPS_PH1)
		else $error("phase 2 did not end at peak");
	AST_TIMEOUT_BOUND: assert property (@(posedge clk) disable iff (rst)
		ce && phase == BBPS_PH1 && $past(phase) != BBPS_PH1 && cmp.vin_above_vout
		&& !buck_only |-> ##[0:16] (phase != BBPS_PH1 || !ce || !running))
		else $error("phase 1 outlived timeout");
	AST_HELPER: assert property (@(posedge clk) disable iff (rst)
		ce && !running |=> !input_helper_on)
		else $error("helper on while stopped");
	AST_SOFTSTART: assert property (@(posedge clk) disable iff (rst)
		ce && !started |=> limits.valley_zero && limits.primary_peak_limit == SS_A)
		else $error("soft-start limits missing");
	AST_ADAPT_OFF: assert property (@(posedge clk) disable iff (rst)
		ce && adaptive_limit_disable |=> limits.valley_zero && !limits.adaptive_on)
		else $error("adaptive off not honoured");
	AST_FORCED_SHUT: assert property (@(posedge clk) disable iff (rst)
		ce && running && cmp.vin_below_uvlo && supply_switchover_force_input
		|=> !running)
		else $error("no shutdown under forced switchover");
	AST_UVLO_FLAG: assert property (@(posedge clk) disable iff (rst)
		ce && running && cmp.vin_below_uvlo && !supply_switchover_force_input
		|=> input_uvlo_flag ##1 (irq || !$past(ce)))
		else $error("uvlo flag or irq missing");
	AST_INTEG: assert property (@(posedge clk) disable iff (rst)
		ce |=> integrator_on == $past(control_loop_config[BIT_INTEGRATOR_ENABLE]))
		else $error("integrator select wrong");
	AST_PH3_ZERO: assert property (@(posedge clk) disable iff (rst)
		ce && running && phase == BBPS_PH3 && cmp.zero_cross
		&& (!limits.adaptive_on || !zero_cross_cmp_disable) |=> phase == BBPS_PH4)
		else $error("zero crossing did not freewheel");
endmodule

//--- tb/bbps_power_stage.sv
`timescale 1ns/10ps
module bbps_power_stage
	import bbps_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire bbps_switch_s sw,
	input  wire bbps_limits_s lim,
	input  wire logic         fast,
	input  wire logic         vin_hi,
	input  wire logic         vin_low,
	input  wire logic         at_target,
	output bbps_cmp_s         cmp
);
	// ----------------------------------------
	// Inductor current, eight units per peak-limit LSB; step 4 fast or 1 slow
	// ----------------------------------------
	int cur;
	int step;
	int valley_lvl;

	always_comb begin
		step       = fast ? 4 : 1;
		valley_lvl = lim.valley_zero ? 0 : 8;
	end

	// Clamped at zero: no reverse current
	always @(posedge clk or posedge rst) begin
		if (rst)
			cur <= 0;
		else if (sw == 4'h9 || (sw == 4'hc && vin_hi))
			cur <= cur + step;
		else if (sw == 4'h6 || sw == 4'hc)
			cur <= (cur > step) ? cur - step : 0;
		else if (sw == 4'h0)
			cur <= 0;
	end

	always_comb begin
		cmp.peak_primary   = cur >= 8 * lim.primary_peak_limit;
		cmp.peak_total     = cur >= 8 * (lim.primary_peak_limit + lim.secondary_peak_limit);
		cmp.valley         = cur <= valley_lvl;
		cmp.zero_cross     = cur == 0;
		cmp.vin_above_vout = vin_hi;
		cmp.vin_below_uvlo = vin_low;
		cmp.vout_at_target = at_target;
		cmp.vout_above_min = 1'b1;
	end
endmodule

//--- tb/buck_boost_phase_sequencer_test.sv
`timescale 1ns/10ps
module buck_boost_phase_sequencer_test;
	import bbps_pkg::*;
	localparam int TO  = 10;
	localparam int FW  = 1;
	localparam int SSA = 4;
	localparam int SSB = 2;
	logic         clk = 0, rst = 1, ce = 1, enable = 0, reg_wr = 0;
	logic         fast = 1, vin_hi = 1, vin_low = 0, at_target = 0;
	logic [7:0]   reg_addr = 0, reg_wdata = 0, reg_rdata, rd_val;
	bbps_cmp_s    cmp_in;
	bbps_switch_s switches;
	bbps_limits_s limits;
	logic         helper, integ, ccm, uvlo_flag, irq, running;
	logic [3:0]   sw, prev_sw = 0, first_sw;
	int           num_errors = 0, cmp_count = 0, bad_sw = 0;
	int           n2, n4, n21, n13, max1, max4, len = 0;

	always #25 clk = ~clk;

	bbps_sequencer #(.TIMEOUT_CYC(TO), .FWHEEL_CYC(FW), .SS_PEAK_A(SSA), .SS_PEAK_B(SSB))
	bbps_sequencer_inst (
		.clk(clk), .rst(rst), .ce(ce), .enable(enable), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.cmp_in(cmp_in), .switches(switches), .input_helper_on(helper),
		.integrator_on(integ), .limits(limits), .ccm_allowed(ccm),
		.input_uvlo_flag(uvlo_flag), .irq(irq), .running(running)
	);

	bbps_power_stage bbps_power_stage_inst (
		.clk(clk), .rst(rst), .sw(switches), .lim(limits), .fast(fast),
		.vin_hi(vin_hi), .vin_low(vin_low), .at_target(at_target), .cmp(cmp_in)
	);

	// ----------------------------------------
	// Phase monitor
	// ----------------------------------------
	always @(posedge clk) begin
		sw = switches;
		if (!rst) begin
			if (!(sw inside {4'h0, 4'hc, 4'h9, 4'h6, 4'h3}))
				bad_sw++;
			if (sw != prev_sw) begin
				if (prev_sw == 4'hc && len > max1)
					max1 = len;
				if (prev_sw == 4'h3 && len > max4)
					max4 = len;
				n4  += (sw == 4'h3);
				n2  += (sw == 4'h9);
				n21 += (prev_sw == 4'h9 && sw == 4'hc);
				n13 += (prev_sw == 4'hc && sw == 4'h6);
				if (first_sw == 0)
					first_sw = sw;
				len = 1;
			end else
				len++;
			prev_sw = sw;
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		@(negedge clk);
		d = reg_rdata;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Monitor counters other than bad_sw restart for each scenario
	task automatic clr;
		n2 = 0;
		n4 = 0;
		n21 = 0;
		n13 = 0;
		max1 = 0;
		max4 = 0;
		first_sw = 0;
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Run should take about 1300 cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		clr();
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 0;
		rd(OFS_SWITCHING_CONFIG, rd_val);
		chk("cfg 01 reset", RST_SWITCHING_CONFIG, rd_val);
		rd(OFS_PEAK_CURRENT_LIMITS, rd_val);
		chk("cfg 03 reset", RST_PEAK_CURRENT_LIMITS, rd_val);
		rd(OFS_CONTROL_LOOP_CONFIG, rd_val);
		chk("cfg 04 reset", RST_CONTROL_LOOP_CONFIG, rd_val);
		chk_bit("integrator at reset", 1'b1, integ);
		wr(8'h03, 8'ha5);
		rd(8'h03, rd_val);
		chk("cfg 03 readback", 8'ha5, rd_val);
		wr(8'h02, 8'h5a);
		rd(8'h02, rd_val);
		chk("unmapped read", 8'h00, rd_val);
		wr(8'h04, 8'h00);
		cyc(2);
		chk_bit("integrator off", 1'b0, integ);
		wr(8'h04, 8'h04);
		cyc(2);
		chk_bit("integrator on", 1'b1, integ);
		// Start-up in buck-boost, primary 2, secondary 1
		wr(8'h03, 8'h12);
		wr(8'h01, 8'h00);
		enable = 1;
		cyc(8);
		chk_bit("running", 1'b1, running);
		chk("soft-start a", 10'(SSA), 10'(limits.primary_peak_limit));
		chk("soft-start b", 10'(SSB), 10'(limits.secondary_peak_limit));
		chk_bit("startup valley zero", 1'b1, limits.valley_zero);
		chk_bit("startup dcm", 1'b0, ccm);
		cyc(60);
		chk("first charge phase", 10'h9, 10'(first_sw));
		chk_bit("phase 2 to 1", 1'b1, n21 > 0);
		chk_bit("phase 1 to 3", 1'b1, n13 > 0);
		chk_bit("phase 1 ends on total", 1'b1, max1 <= 6);
		at_target = 1;
		cyc(8);
		chk_bit("ccm allowed", 1'b1, ccm);
		chk("primary restored", 10'h2, 10'(limits.primary_peak_limit));
		chk("secondary restored", 10'h1, 10'(limits.secondary_peak_limit));
		chk_bit("adaptive valley", 1'b0, limits.valley_zero);
		// Slow ramp with huge total: timeout ends phase 1
		fast = 0;
		wr(8'h03, 8'hf2);
		cyc(30);
		clr();
		cyc(200);
		chk_bit("timeout phase 1 seen", 1'b1, n21 > 0);
		chk("phase 1 timeout", 10'(TO), 10'(max1));
		// Vin below Vout: phase 1 ends at valley
		fast = 1;
		vin_hi = 0;
		wr(8'h03, 8'hf1);
		cyc(30);
		clr();
		cyc(200);
		chk_bit("phase 1 valley exit", 1'b1, max1 > 0 && max1 <= TO - 3);
		// Comparator on, CCM: no freewheel
		fast = 0;
		vin_hi = 1;
		wr(8'h03, 8'h12);
		cyc(30);
		clr();
		cyc(200);
		chk("ccm no phase 4", 10'h0, 10'(n4));
		wr(8'h01, 8'h10);
		cyc(30);
		clr();
		cyc(200);
		chk_bit("ccm phase 4 inserted", 1'b1, n4 > 0);
		chk("ccm phase 4 length", 10'(FW), 10'(max4));
		wr(8'h04, 8'h06);
		cyc(4);
		chk_bit("fixed valley", 1'b1, limits.valley_zero);
		chk_bit("adaptive off", 1'b0, limits.adaptive_on);
		chk("fixed primary", 10'h2, 10'(limits.primary_peak_limit));
		// Buck-only never uses phase 2
		wr(8'h04, 8'h04);
		wr(8'h01, 8'h04);
		cyc(30);
		clr();
		cyc(200);
		chk("buck-only phase 2", 10'h0, 10'(n2));
		chk_bit("buck-only 1 to 3", 1'b1, n13 > 0);
		// Input lockout with switchover clear keeps running
		wr(8'h01, 8'h00);
		vin_low = 1;
		cyc(8);
		chk_bit("running low vin", 1'b1, running);
		chk_bit("helper on", 1'b1, helper);
		chk_bit("uvlo flag", 1'b1, uvlo_flag);
		chk_bit("uvlo irq", 1'b1, irq);
		vin_low = 0;
		cyc(6);
		chk_bit("helper off", 1'b0, helper);
		chk_bit("flag sticky", 1'b1, uvlo_flag);
		wr(8'h01, 8'h00);
		cyc(3);
		chk_bit("flag cleared", 1'b0, uvlo_flag);
		chk_bit("irq cleared", 1'b0, irq);
		wr(8'h01, 8'h01);
		vin_low = 1;
		cyc(8);
		chk_bit("forced shutdown", 1'b0, running);
		chk_bit("helper off stopped", 1'b0, helper);
		chk("switches idle", 10'h0, 10'(switches));
		chk("illegal switch pairs", 10'h0, 10'(bad_sw));
		final_report();
	end
endmodule
